/* File: dual_adc_ctrl.sv */
// Control block of two successive-approximation converters with AHB-Lite registers.
// Assumes one AHB-Lite master, synchronous start and timer inputs, analog results on ports.
`timescale 1ns/1ps
`default_nettype none

module dual_adc_ctrl
    import adc_ctrl_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic timer3_overflow,
    input wire logic timer2_overflow,
    input wire logic first_ext_start_pin,
    input wire logic second_ext_start_pin,
    input wire logic [15:0] first_sample_data,
    input wire logic [15:0] second_sample_data,
    input wire logic [15:0] diff_sample_data,
    output logic first_converter_busy,
    output logic second_converter_busy,
    output logic first_conv_clk,
    output logic second_conv_clk,
    output logic first_tracking,
    output logic second_tracking,
    output logic first_shutdown,
    output logic second_shutdown,
    output logic first_gain_cal,
    output logic first_offset_cal,
    output logic second_gain_cal,
    output logic second_offset_cal,
    output logic first_bias_generator_enable,
    output logic second_bias_generator_enable,
    output logic first_reference_buffer_enable,
    output logic second_reference_buffer_enable,
    output logic first_done_irq,
    output logic second_done_irq
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [7:0] ctl0;
        logic [7:0] ctl1;
        logic [7:0] cfg0;
        logic [7:0] cfg1;
        logic diff;
        logic [1:0] ref0;
        logic [1:0] ref1;
        logic done0;
        logic done1;
        logic [15:0] res0;
        logic [15:0] res1;
        logic [31:0] rdata;
    } ctrl_state_type;

    ctrl_state_type s_r;
    ctrl_state_type s_nxt;

    logic busy0;
    logic busy1;
    logic fin0;
    logic fin1;
    logic ext_rise0;
    logic ext_rise1;
    logic sw_busy0;
    logic sw_busy1;
    logic start0;
    logic start1;
    logic en0;
    logic en1;
    logic tm0;
    logic tm1;
    logic skip0;
    logic skip1;
    logic [3:0] div0;
    logic [3:0] div1;
    logic addr_phase;
    logic wr_data;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Start source selected by a start-mode code
    function automatic logic start_pick(
        input logic [2:0] mode,
        input logic sw,
        input logic t3,
        input logic ext,
        input logic t2,
        input logic sw_first
    );
        logic hit;
        hit = 1'b0;
        unique case (mode)
            SRC_SW: hit = sw;
            SRC_T3: hit = t3;
            SRC_EXT: hit = ext;
            SRC_T2: hit = t2;
            SRC_SW_FIRST: hit = sw_first;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : start_pick

    // Control register image with live busy and done bits
    function automatic logic [31:0] ctl_image(
        input logic [7:0] ctl,
        input logic done,
        input logic busy
    );
        logic [7:0] img;
        img = ctl;
        img[CTL_DONE_BIT] = done;
        img[CTL_BUSY_BIT] = busy;
        return {24'h0000_00, img};
    endfunction : ctl_image

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign addr_phase = hsel && hready && htrans[1];
    assign wr_data = s_r.wr_pend;
    // Writing 1 to a busy bit is a software start request
    assign sw_busy0 = wr_data && (s_r.wr_addr == OFS_CTL0) && hwdata[CTL_BUSY_BIT];
    assign sw_busy1 = wr_data && (s_r.wr_addr == OFS_CTL1) && hwdata[CTL_BUSY_BIT];

    // ------------------------------------------------------------
    // Converter settings and start selection
    // ------------------------------------------------------------
    assign en0 = s_r.ctl0[CTL_EN_BIT];
    assign tm0 = s_r.ctl0[CTL_TM_BIT];
    assign div0 = s_r.cfg0[CFG_DIV_LSB +: 4];
    assign start0 = start_pick({1'b0, s_r.ctl0[1:0]}, sw_busy0, timer3_overflow,
                               ext_rise0, timer2_overflow, 1'b0);
    assign skip0 = ({1'b0, s_r.ctl0[1:0]} == SRC_EXT);

    always_comb begin
        en1 = s_r.ctl1[CTL_EN_BIT];
        tm1 = s_r.ctl1[CTL_TM_BIT];
        div1 = s_r.cfg1[CFG_DIV_LSB +: 4];
        skip1 = (s_r.ctl1[2:0] == SRC_EXT);
        start1 = start_pick(s_r.ctl1[2:0], sw_busy1, timer3_overflow, ext_rise1,
                            timer2_overflow, sw_busy0);
        if (s_r.diff) begin
            // Paired mode slaves the second converter to the first, its divider only while its calibration bits are clear
            en1 = en0;
            tm1 = tm0;
            skip1 = skip0;
            start1 = start0;
            if (!(s_r.cfg1[CFG_GCAL_BIT] || s_r.cfg1[CFG_OCAL_BIT])) begin
                div1 = div0;
            end
        end
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        // Address phase
        s_nxt.wr_pend = addr_phase && hwrite;
        if (addr_phase) begin
            s_nxt.wr_addr = haddr[7:0];
        end
        if (addr_phase && !hwrite) begin
            unique case (haddr[7:0])
                OFS_CTL0: s_nxt.rdata = ctl_image(s_r.ctl0, s_r.done0, busy0);
                OFS_CTL1: s_nxt.rdata = ctl_image(s_r.ctl1, s_r.done1, busy1);
                OFS_CFG0: s_nxt.rdata = {24'h0000_00, s_r.cfg0};
                OFS_CFG1: s_nxt.rdata = {24'h0000_00, s_r.cfg1};
                OFS_MUX: s_nxt.rdata = {25'h000_0000, s_r.diff, 6'h00};
                OFS_REF0: s_nxt.rdata = {30'h0000_0000, s_r.ref0};
                OFS_REF1: s_nxt.rdata = {30'h0000_0000, s_r.ref1};
                OFS_RES0_HI: s_nxt.rdata = {24'h0000_00, s_r.res0[15:8]};
                OFS_RES0_LO: s_nxt.rdata = {24'h0000_00, s_r.res0[7:0]};
                OFS_RES1_HI: s_nxt.rdata = {24'h0000_00, s_r.res1[15:8]};
                OFS_RES1_LO: s_nxt.rdata = {24'h0000_00, s_r.res1[7:0]};
                default: s_nxt.rdata = 32'h0000_0000;
            endcase
        end

        // Data phase of a write
        if (wr_data) begin
            unique case (s_r.wr_addr)
                OFS_CTL0: begin
                    s_nxt.ctl0 = hwdata[7:0] & 8'hCB;
                    if (!hwdata[CTL_DONE_BIT]) begin
                        s_nxt.done0 = 1'b0;
                    end
                end
                OFS_CTL1: begin
                    s_nxt.ctl1 = hwdata[7:0] & 8'hCF;
                    if (!hwdata[CTL_DONE_BIT]) begin
                        s_nxt.done1 = 1'b0;
                    end
                end
                OFS_CFG0: s_nxt.cfg0 = hwdata[7:0];
                OFS_CFG1: s_nxt.cfg1 = hwdata[7:0];
                OFS_MUX: s_nxt.diff = hwdata[MUX_DIFF_BIT];
                OFS_REF0: s_nxt.ref0 = hwdata[1:0];
                OFS_REF1: s_nxt.ref1 = hwdata[1:0];
                default: s_nxt.ctl0 = s_nxt.ctl0;
            endcase
        end

        // Completion sets the flag and wins over a clear in the same cycle
        if (fin0) begin
            s_nxt.done0 = 1'b1;
            s_nxt.res0 = s_r.diff ? diff_sample_data : first_sample_data;
        end
        if (fin1) begin
            s_nxt.done1 = 1'b1;
            if (!s_r.diff) begin
                s_nxt.res1 = second_sample_data;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '{ctl0: CTL_RESET, ctl1: CTL_RESET, cfg0: CFG_RESET, cfg1: CFG_RESET,
                     ref0: REF_RESET, ref1: REF_RESET, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // External start edges
    // ------------------------------------------------------------
    start_edge_detect u_edge0 (
        .hclk(hclk),
        .hresetn(hresetn),
        .level(first_ext_start_pin),
        .rise(ext_rise0)
    );

    start_edge_detect u_edge1 (
        .hclk(hclk),
        .hresetn(hresetn),
        .level(second_ext_start_pin),
        .rise(ext_rise1)
    );

    // ------------------------------------------------------------
    // Converter sequencers
    // ------------------------------------------------------------
    conv_sequencer u_seq0 (
        .hclk(hclk),
        .hresetn(hresetn),
        .enable(en0),
        .tracking_mode(tm0),
        .skip_track(skip0),
        .start(start0),
        .div_code(div0),
        .busy(busy0),
        .done(fin0),
        .tracking(first_tracking),
        .conv_clk(first_conv_clk),
        .shutdown(first_shutdown)
    );

    conv_sequencer u_seq1 (
        .hclk(hclk),
        .hresetn(hresetn),
        .enable(en1),
        .tracking_mode(tm1),
        .skip_track(skip1),
        .start(start1),
        .div_code(div1),
        .busy(busy1),
        .done(fin1),
        .tracking(second_tracking),
        .conv_clk(second_conv_clk),
        .shutdown(second_shutdown)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_r.rdata;
    assign first_converter_busy = busy0;
    assign second_converter_busy = busy1;
    assign first_done_irq = s_r.done0 & s_r.ctl0[CTL_IE_BIT];
    assign second_done_irq = s_r.done1 & s_r.ctl1[CTL_IE_BIT];
    assign first_gain_cal = s_r.cfg0[CFG_GCAL_BIT];
    assign first_offset_cal = s_r.cfg0[CFG_OCAL_BIT];
    assign second_gain_cal = s_r.cfg1[CFG_GCAL_BIT];
    assign second_offset_cal = s_r.cfg1[CFG_OCAL_BIT];
    assign first_bias_generator_enable = s_r.ref0[REF_BIAS_BIT];
    assign second_bias_generator_enable = s_r.ref1[REF_BIAS_BIT];
    assign first_reference_buffer_enable = s_r.ref0[REF_BUF_BIT];
    assign second_reference_buffer_enable = s_r.ref1[REF_BUF_BIT];

    // Bus width and size are not checked: only whole-word singles are issued
    logic unused_ok;
    assign unused_ok = ^{haddr[31:8], hsize, htrans[0], hwdata[31:8]};
endmodule : dual_adc_ctrl
`default_nettype wire

/* File: adc_ctrl_pkg.sv */
// Constants, register map and timing tables of the dual converter control block.
// Assumes a 250 MHz system clock and one AHB-Lite master.
package adc_ctrl_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTL0 = 8'h00;
    localparam logic [7:0] OFS_CTL1 = 8'h04;
    localparam logic [7:0] OFS_CFG0 = 8'h08;
    localparam logic [7:0] OFS_CFG1 = 8'h0C;
    localparam logic [7:0] OFS_MUX = 8'h10;
    localparam logic [7:0] OFS_REF0 = 8'h14;
    localparam logic [7:0] OFS_REF1 = 8'h18;
    localparam logic [7:0] OFS_RES0_HI = 8'h1C;
    localparam logic [7:0] OFS_RES0_LO = 8'h20;
    localparam logic [7:0] OFS_RES1_HI = 8'h24;
    localparam logic [7:0] OFS_RES1_LO = 8'h28;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTL_EN_BIT = 7;
    localparam int CTL_TM_BIT = 6;
    localparam int CTL_DONE_BIT = 5;
    localparam int CTL_BUSY_BIT = 4;
    localparam int CTL_IE_BIT = 3;
    localparam int CFG_DIV_LSB = 4;
    localparam int CFG_GCAL_BIT = 2;
    localparam int CFG_OCAL_BIT = 0;
    localparam int MUX_DIFF_BIT = 6;
    localparam int REF_BIAS_BIT = 1;
    localparam int REF_BUF_BIT = 0;

    // ------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET = 8'hF0;
    localparam logic [1:0] REF_RESET = 2'h0;
    localparam logic [2:0] SRC_SW = 3'h0;
    localparam logic [2:0] SRC_T3 = 3'h1;
    localparam logic [2:0] SRC_EXT = 3'h2;
    localparam logic [2:0] SRC_T2 = 3'h3;
    localparam logic [2:0] SRC_SW_FIRST = 3'h4;

    // ------------------------------------------------------------
    // Conversion durations in system clocks, indexed by divider code
    // ------------------------------------------------------------
    localparam logic [15:0][9:0] CONV_TIME_TM0 = {
        10'h12C, 10'h11A, 10'h107, 10'h0F5, 10'h0E2, 10'h0D0, 10'h0BD, 10'h0AB,
        10'h098, 10'h086, 10'h073, 10'h061, 10'h04E, 10'h03A, 10'h028, 10'h015};
    localparam logic [15:0][9:0] CONV_TIME_TM1 = {
        10'h22C, 10'h20A, 10'h1E7, 10'h1C5, 10'h1A2, 10'h180, 10'h15D, 10'h13B,
        10'h118, 10'h0F6, 10'h0D3, 10'h0B1, 10'h08E, 10'h06A, 10'h048, 10'h026};

    function automatic logic [9:0] conv_len(input logic [3:0] code);
        return CONV_TIME_TM0[code];
    endfunction : conv_len

    function automatic logic [9:0] track_len(input logic [3:0] code);
        return CONV_TIME_TM1[code] - CONV_TIME_TM0[code];
    endfunction : track_len

endpackage : adc_ctrl_pkg

/* File: start_edge_detect.sv */
// Rising edge detector for an external start-of-conversion input.
// Assumes the input is synchronous to hclk.
`timescale 1ns/1ps
`default_nettype none
module start_edge_detect
    import adc_ctrl_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic level,
    output logic rise
);
    typedef struct packed {
        logic prev;
    } edge_state_type;

    edge_state_type s_r;
    edge_state_type s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.prev = level;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Only a low-to-high step starts a conversion
    assign rise = level & ~s_r.prev;
endmodule : start_edge_detect
`default_nettype wire

/* File: conv_sequencer.sv */
// Track, convert and completion sequencing of one converter.
// Assumes start is a one-cycle pulse in hclk.
`timescale 1ns/1ps
`default_nettype none
module conv_sequencer
    import adc_ctrl_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic enable,
    input wire logic tracking_mode,
    input wire logic skip_track,
    input wire logic start,
    input wire logic [3:0] div_code,
    output logic busy,
    output logic done,
    output logic tracking,
    output logic conv_clk,
    output logic shutdown
);
    typedef enum logic [1:0] {PH_IDLE, PH_TRACK, PH_CONV} phase_type;
    typedef struct packed {
        phase_type phase;
        logic [9:0] cnt;
        logic [3:0] div;
        logic clk;
        logic done;
    } seq_state_type;

    seq_state_type s_r;
    seq_state_type s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        s_nxt.clk = 1'b0;
        unique case (s_r.phase)
            PH_IDLE: begin
                // Starts while busy never reach here
                if (enable && start) begin
                    s_nxt.div = 4'h0;
                    if (tracking_mode && !skip_track) begin
                        s_nxt.phase = PH_TRACK;
                        s_nxt.cnt = track_len(div_code) - 10'h001;
                    end else begin
                        s_nxt.phase = PH_CONV;
                        s_nxt.cnt = conv_len(div_code) - 10'h001;
                    end
                end
            end
            PH_TRACK: begin
                if (s_r.cnt == 10'h000) begin
                    s_nxt.phase = PH_CONV;
                    s_nxt.cnt = conv_len(div_code) - 10'h001;
                end else begin
                    s_nxt.cnt = s_r.cnt - 10'h001;
                end
            end
            PH_CONV: begin
                // Conversion clock period is code plus one system clocks
                if (s_r.div == div_code) begin
                    s_nxt.div = 4'h0;
                    s_nxt.clk = (s_r.cnt != 10'h000);
                end else begin
                    s_nxt.div = s_r.div + 4'h1;
                end
                if (s_r.cnt == 10'h000) begin
                    s_nxt.phase = PH_IDLE;
                    s_nxt.done = 1'b1;
                end else begin
                    s_nxt.cnt = s_r.cnt - 10'h001;
                end
            end
        endcase
        // Disabled converter drops to shutdown at once
        if (!enable) begin
            s_nxt.phase = PH_IDLE;
            s_nxt.done = 1'b0;
            s_nxt.clk = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '{phase: PH_IDLE, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy = (s_r.phase != PH_IDLE);
    assign done = s_r.done;
    assign tracking = enable && (s_r.phase != PH_CONV);
    assign conv_clk = s_r.clk;
    assign shutdown = ~enable;
endmodule : conv_sequencer
`default_nettype wire

/* File: adc_ctrl_monitor.sv */
// Port checker of the dual converter control block.
// Bound into dual_adc_ctrl; sees only its ports, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic first_converter_busy,
    input wire logic second_converter_busy,
    input wire logic first_conv_clk,
    input wire logic second_conv_clk,
    input wire logic first_tracking,
    input wire logic second_tracking,
    input wire logic first_shutdown,
    input wire logic second_shutdown
);
    // ----
    // Busy run length counters
    // ----
    logic [9:0] len0_r;
    logic [9:0] len1_r;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            len0_r <= 10'h000;
            len1_r <= 10'h000;
        end else begin
            len0_r <= first_converter_busy ? len0_r + 10'h001 : 10'h000;
            len1_r <= second_converter_busy ? len1_r + 10'h001 : 10'h000;
        end
    end
    // ----
    // Assertions
    // ----
    off_idle0_a:
        assert property (first_shutdown |=> !first_converter_busy) else $error("busy0 off");
    off_idle1_a:
        assert property (second_shutdown |=> !second_converter_busy) else $error("busy1 off");
    idle_track0_a:
        assert property (!first_converter_busy && !first_shutdown |-> first_tracking)
        else $error("idle0 not tracking");
    idle_track1_a:
        assert property (!second_converter_busy && !second_shutdown |-> second_tracking)
        else $error("idle1 not tracking");
    clk_phase0_a:
        assert property (first_conv_clk |-> first_converter_busy && !first_tracking)
        else $error("conv clock0 outside conversion");
    clk_phase1_a:
        assert property (second_conv_clk |-> second_converter_busy && !second_tracking)
        else $error("conv clock1 outside conversion");
    busy_len0_a:
        assert property ($fell(first_converter_busy) && !first_shutdown |->
            len0_r >= 10'h015 && len0_r <= 10'h22c) else $error("busy0 length");
    busy_len1_a:
        assert property ($fell(second_converter_busy) && !second_shutdown |->
            len1_r >= 10'h015 && len1_r <= 10'h22c) else $error("busy1 length");
    cover property ($fell(first_converter_busy));
    cover property ($fell(second_converter_busy));
    cover property (first_converter_busy && first_tracking);
endmodule : adc_ctrl_monitor
bind dual_adc_ctrl adc_ctrl_monitor mon (.hclk, .hresetn, .first_converter_busy,
    .second_converter_busy, .first_conv_clk, .second_conv_clk, .first_tracking,
    .second_tracking, .first_shutdown, .second_shutdown);
`default_nettype wire

/* File: far_side_model.sv */
// Model of timers, start pins and analog results around the block.
// Commanded by the bench; synchronous to hclk.
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
    input wire logic hclk,
    input wire logic fire,
    input wire logic [1:0] kind,
    output logic timer3_overflow,
    output logic timer2_overflow,
    output logic pin_level,
    output logic [15:0] data0,
    output logic [15:0] data1,
    output logic [15:0] datad
);
    // ----
    // Kind 0 timer 3, 1 timer 2, 2 pin pulse, 3 new samples
    // ----
    logic [2:0] pin_sr_r = 3'h0;
    initial begin
        {timer3_overflow, timer2_overflow} = 2'h0;
        {data0, data1, datad} = 48'h0000_0000_0000;
    end
    assign pin_level = |pin_sr_r;
    always @(posedge hclk) begin
        timer3_overflow <= fire && kind == 2'h0;
        timer2_overflow <= fire && kind == 2'h1;
        pin_sr_r <= {pin_sr_r[1:0], fire && kind == 2'h2};
        if (fire && kind == 2'h3) begin
            {data0, data1, datad} <= 48'({$urandom, $urandom});
        end
    end
endmodule : far_side_model
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench of the dual converter control block.
// Drives AHB-Lite and the far-side model; expectations from its own tables.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import adc_ctrl_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic fire = 1'b0;
    logic clr = 1'b0;
    logic [1:0] kind = 2'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    wire logic hreadyout, hresp, timer3_overflow, timer2_overflow, pin;
    wire logic first_converter_busy, second_converter_busy, first_done_irq, first_shutdown;
    wire logic first_bias_generator_enable, second_done_irq;
    wire logic [31:0] hrdata;
    wire logic [15:0] d0, d1, dd;
    int bad_count = 0;
    int n_tests = 0;
    int n0 = 0;
    int n1 = 0;
    int t0[16] = '{21, 40, 58, 78, 97, 115, 134, 152, 171, 189, 208, 226, 245, 263, 282, 300};
    int t1[16] = '{38, 72, 106, 142, 177, 211, 246, 280, 315, 349, 384, 418, 453, 487, 522, 556};
    always #2 hclk = ~hclk;
    always @(posedge hclk) begin
        n0 <= clr ? 0 : n0 + int'(first_converter_busy);
        n1 <= clr ? 0 : n1 + int'(second_converter_busy);
    end
    far_side_model far (.hclk, .fire, .kind, .timer3_overflow, .timer2_overflow,
        .pin_level(pin), .data0(d0), .data1(d1), .datad(dd));
    dual_adc_ctrl dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .timer3_overflow, .timer2_overflow,
        .first_ext_start_pin(pin), .second_ext_start_pin(pin), .first_sample_data(d0),
        .second_sample_data(d1), .diff_sample_data(dd), .first_converter_busy,
        .second_converter_busy, .first_conv_clk(), .second_conv_clk(), .first_tracking(),
        .second_tracking(), .first_shutdown, .second_shutdown(), .first_gain_cal(),
        .first_offset_cal(), .second_gain_cal(), .second_offset_cal(),
        .first_bias_generator_enable, .second_bias_generator_enable(),
        .first_reference_buffer_enable(), .second_reference_buffer_enable(),
        .first_done_irq, .second_done_irq);
    // ----
    // Checking and bus tasks
    // ----
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rdy();
        int i;
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (hreadyout !== 1'b1 && i < 50);
        if (hreadyout !== 1'b1) begin
            bad_count++;
            finish_test();
        end
    endtask : rdy
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= 32'(a);
        hwrite <= w;
        htrans <= 2'h2;
        rdy();
        htrans <= 2'h0;
        hwdata <= 32'(d);
        rdy();
        r = hrdata;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask : wr
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        xfer(1'b0, a, 8'h00, r);
        chk(nm, e, r);
    endtask : rd_chk
    task automatic run(input logic c, input logic [2:0] m, input logic tm,
                       input logic [3:0] code, input logic dif);
        logic [7:0] o;
        logic [31:0] r;
        logic [15:0] v;
        int i;
        o = c ? 8'h04 : 8'h00;
        wr(OFS_CTL0, 8'h00);
        wr(OFS_CTL1, 8'h00);
        kind <= 2'h3;
        wr(OFS_CFG0 + o, {code, 4'h0});
        wr(o, {1'b1, tm, 3'b001, m});
        clr <= 1'b1;
        fire <= 1'b1;
        @(posedge hclk);
        clr <= 1'b0;
        fire <= 1'b0;
        case (m)
            3'h0: wr(o, {1'b1, tm, 3'b011, m});
            3'h4: wr(OFS_CTL0, 8'h90);
            default: begin
                kind <= m == 3'h1 ? 2'h0 : (m == 3'h3 ? 2'h1 : 2'h2);
                repeat (2) begin
                    @(posedge hclk);
                    fire <= 1'b1;
                    @(posedge hclk);
                    fire <= 1'b0;
                    repeat (6) @(posedge hclk);
                end
            end
        endcase
        i = 0;
        do begin
            xfer(1'b0, o, 8'h00, r);
            i++;
        end while (r[5] !== 1'b1 && i < 400);
        chk("done flag", 32'h1, 32'(r[5]));
        if (r[5] !== 1'b1) finish_test();
        chk("busy bit", 32'h0, 32'(r[4]));
        i = (tm && m != 3'h2) ? t1[code] : t0[code];
        chk("busy cycles", i, c ? n1 : n0);
        if (dif) chk("paired busy cycles", i, n1);
        chk("done irq", 32'h1, 32'(c ? second_done_irq : first_done_irq));
        v = dif ? dd : (c ? d1 : d0);
        rd_chk("result high", OFS_RES0_HI + (o << 1), 32'(v[15:8]));
        rd_chk("result low", OFS_RES0_LO + (o << 1), 32'(v[7:0]));
        repeat (20) @(posedge hclk);
        xfer(1'b0, o, 8'h00, r);
        chk("done held", 32'h1, 32'(r[5]));
        wr(o, 8'h80);
        xfer(1'b0, o, 8'h00, r);
        chk("done cleared", 32'h0, 32'(r[5]));
    endtask : run
    // ----
    // Main sequence
    // ----
    initial begin
        logic c;
        void'($urandom(32'he7a2_e75b));
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk("config reset", OFS_CFG0, 32'h0000_00f0);
        rd_chk("control reset", OFS_CTL1, 32'h0000_0000);
        wr(8'h40, 8'hff);
        rd_chk("unmapped", 8'h40, 32'h0000_0000);
        wr(OFS_REF0, 8'h02);
        wr(OFS_REF1, 8'h03);
        rd_chk("reference", OFS_REF0, 32'h0000_0002);
        chk("bias out", 32'h1, 32'(first_bias_generator_enable));
        wr(OFS_CTL0, 8'h10);
        repeat (5) @(posedge hclk);
        chk("busy while off", 32'h0, 32'(first_converter_busy));
        chk("shutdown", 32'h1, 32'(first_shutdown));
        run(1'b0, 3'h2, 1'b1, 4'h0, 1'b0);
        run(1'b0, 3'h0, 1'b1, 4'hf, 1'b0);
        run(1'b1, 3'h4, 1'b0, 4'h0, 1'b0);
        for (int k = 0; k < 8; k++) begin
            c = 1'($urandom % 2);
            run(c, 3'($urandom % (c ? 5 : 4)), 1'($urandom % 2), 4'($urandom % 16), 1'b0);
        end
        wr(OFS_MUX, 8'h40);
        run(1'b0, 3'h1, 1'b0, 4'h3, 1'b1);
        finish_test();
    end
endmodule : testbench
`default_nettype wire
